// >>> design/wbc_defines.svh
// wbc_defines.svh: geometry, reset values and timing counts of the unified
// cache. Included by bare name from wbc_lru, wbc_wbuf and wbc_cache.
// How it works
// [RL1] 8K bytes shared by code and data, four ways per set.
// [RL2] victim way of a set picked by least-recently-used order.
// [RL3] 16-byte lines, allocated on read misses only, never on writes.
// [RL4] one valid flag per line, one modified flag per double word.
// [RL5] replacement writes back only the modified double words.
// [RL6] core read or write hit completes in one core clock.
// [RL7] cache runs in write-back or write-through mode.
// [RL8] write-through: every cache write also goes to external memory.
// [RL9] write-back: write hits update only the cache.
// [RL10] 32-bit single-cycle core access, writes posted via two-deep buffer.
// [RL11] core at three times bus clock, bus logic at input clock rate.
// [RL12] warm restart keeps all valid and modified flags unchanged.
// [RL13] lru state updated on every hit and every line fill.
`ifndef WBC_DEFINES_SVH
`define WBC_DEFINES_SVH

`define WBC_CACHE_BYTES 8192
`define WBC_WAYS 4
`define WBC_LINE_BYTES 16
`define WBC_WORDS 4
`define WBC_SETS 128
`define WBC_LINES 512
`define WBC_DWORDS 2048
`define WBC_IDX_W 7
`define WBC_TAG_W 21
`define WBC_IDX_LSB 4
`define WBC_TAG_LSB 11
`define WBC_WORD_LSB 2
`define WBC_WBUF_DEPTH 2
`define WBC_CLK_RATIO 3
`define WBC_LRU_RESET 8'he4
`define WBC_BE_ALL 4'hf

`endif

// >>> design/wbc_pkg.sv
// wbc_pkg: types shared by the cache sources.
// assumes nothing of its surroundings.
package wbc_pkg;
   typedef enum logic [1:0] {
      WBC_IDLE = 2'b00,
      WBC_DRAIN = 2'b01,
      WBC_WBACK = 2'b10,
      WBC_FILL = 2'b11
   } wbc_state_t;
   typedef logic [1:0] wbc_way_t;
endpackage : wbc_pkg

// >>> design/wbc_lru.sv
// wbc_lru: true least-recently-used age table, one 2-bit age per way.
// assumes one touch per cycle; ages survive warm restart.
`timescale 1ns/1ps
`default_nettype none
`include "wbc_defines.svh"
module wbc_lru #(
   parameter int SETS = `WBC_SETS,
   parameter int IDX_W = `WBC_IDX_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic touch,
   input wire logic [IDX_W-1:0] touch_set,
   input wire wbc_pkg::wbc_way_t touch_way,
   input wire logic [IDX_W-1:0] query_set,
   output wbc_pkg::wbc_way_t victim
);
   import wbc_pkg::*;

   logic [7:0] age_q [SETS];

   // touched way becomes youngest, younger ones age by one
   function automatic logic [7:0] aged(input logic [7:0] a,
                                       input wbc_way_t w);
      logic [7:0] r;
      logic [1:0] ai;
      logic [1:0] aw;
      r = a;
      aw = a[2*w +: 2];
      for (int i = 0; i < 4; i++) begin
         ai = a[2*i +: 2];
         if (2'(i) == w) begin
            r[2*i +: 2] = 2'h0;
         end else if (ai < aw) begin
            r[2*i +: 2] = ai + 2'h1;
         end
      end
      return r;
   endfunction : aged

   function automatic wbc_way_t oldest(input logic [7:0] a);
      wbc_way_t r;
      r = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (a[2*i +: 2] == 2'h3) begin
            r = 2'(i);
         end
      end
      return r;
   endfunction : oldest

   assign victim = oldest(age_q[query_set]); // RL2

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int s = 0; s < SETS; s++) begin
            age_q[s] <= `WBC_LRU_RESET;
         end
      end else if (touch) begin
         age_q[touch_set] <= aged(age_q[touch_set], touch_way); // RL13
      end
   end
endmodule : wbc_lru
`default_nettype wire

// >>> design/wbc_wbuf.sv
// wbc_wbuf: posted-write queue between core and bus engine.
// assumes the consumer pops only while pop_valid is high.
`timescale 1ns/1ps
`default_nettype none
`include "wbc_defines.svh"
module wbc_wbuf #(
   parameter int DW = 68,
   parameter int DEPTH = `WBC_WBUF_DEPTH
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic push_valid,
   output logic push_ready,
   input wire logic [DW-1:0] push_data,
   output logic pop_valid,
   input wire logic pop_ready,
   output logic [DW-1:0] pop_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = PW + 1;

   logic [DW-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   wire push_ok = push_valid && push_ready;
   wire pop_ok = pop_valid && pop_ready;

   function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction : next_ptr

   assign push_ready = cnt_q != CW'(DEPTH); // RL10
   assign pop_valid = cnt_q != '0;
   assign pop_data = mem_q[rd_q];

   always_ff @(posedge sys_clk) begin
      if (push_ok) begin
         mem_q[wr_q] <= push_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push_ok) wr_q <= next_ptr(wr_q);
         if (pop_ok) rd_q <= next_ptr(rd_q);
         cnt_q <= cnt_q + CW'(push_ok) - CW'(pop_ok);
      end
   end
endmodule : wbc_wbuf
`default_nettype wire

// >>> design/wbc_cache.sv
// wbc_cache: 8K four-way unified cache with posted writes and a bus engine
// that runs one input-clock period per three core clocks.
// assumes core inputs are synchronous to sys_clk and held while core_req is
// high and core_gnt low; the bus partner holds bus_ack for a full bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "wbc_defines.svh"
module wbc_cache (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic warm_restart_in,
   input wire logic wb_mode_in,
   input wire logic core_req,
   input wire logic core_we,
   input wire logic [31:0] core_addr,
   input wire logic [31:0] core_wdata,
   input wire logic [3:0] core_be,
   output logic core_gnt,
   output logic core_rvalid,
   output logic [31:0] core_rdata,
   output logic bus_clk_out,
   output logic bus_req,
   output logic bus_we,
   output logic [31:0] bus_addr,
   output logic [31:0] bus_wdata,
   output logic [3:0] bus_be,
   input wire logic bus_ack,
   input wire logic [31:0] bus_rdata
);
   import wbc_pkg::*;

   localparam int WB_DW = 68;

   function automatic logic [8:0] line_ix(input wbc_way_t w,
                                          input logic [6:0] s);
      return {w, s};
   endfunction : line_ix

   function automatic logic [10:0] word_ix(input wbc_way_t w,
                                           input logic [6:0] s,
                                           input logic [1:0] d);
      return {w, s, d};
   endfunction : word_ix

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction : merge

   function automatic wbc_way_t onehot_way(input logic [3:0] h);
      wbc_way_t r;
      r = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (h[i]) r = 2'(i);
      end
      return r;
   endfunction : onehot_way

   // an empty way is always filled before any valid line is evicted
   function automatic wbc_way_t pick_victim(input logic [3:0] v,
                                            input wbc_way_t lru);
      wbc_way_t r;
      r = lru;
      for (int i = 3; i >= 0; i--) begin
         if (!v[i]) r = 2'(i);
      end
      return r;
   endfunction : pick_victim

   // storage: tags, data, one valid per line, one dirty per double word
   logic [`WBC_TAG_W-1:0] tag_mem [`WBC_LINES]; // RL1
   logic [31:0] data_mem [`WBC_DWORDS]; // RL3
   logic [`WBC_LINES-1:0] valid_q; // RL4
   logic [`WBC_DWORDS-1:0] dirty_q; // RL4

   wbc_state_t state_q;
   logic [`WBC_TAG_W-1:0] m_tag_q;
   logic [`WBC_IDX_W-1:0] m_idx_q;
   wbc_way_t vict_q;
   logic [1:0] cnt_q;
   logic [1:0] phase_q;
   logic bus_clk_q;
   logic bus_busy_q;
   logic bus_fsm_q;
   logic bus_we_q;
   logic [31:0] bus_addr_q;
   logic [31:0] bus_wdata_q;
   logic [3:0] bus_be_q;
   logic core_rvalid_q;
   logic [31:0] core_rdata_q;

   // warm restart aborts work in flight but never touches the flag arrays
   wire op_rst = sys_rst || warm_restart_in; // RL12

   wire [`WBC_IDX_W-1:0] idx = core_addr[`WBC_TAG_LSB-1:`WBC_IDX_LSB];
   wire [`WBC_TAG_W-1:0] tag = core_addr[31:`WBC_TAG_LSB];
   wire [1:0] word = core_addr[`WBC_IDX_LSB-1:`WBC_WORD_LSB];

   logic [3:0] way_hit;
   logic [3:0] way_valid;
   for (genvar w = 0; w < `WBC_WAYS; w++) begin : g_way
      assign way_valid[w] = valid_q[line_ix(2'(w), idx)];
      assign way_hit[w] = way_valid[w] &&
                          (tag_mem[line_ix(2'(w), idx)] == tag);
   end

   wire hit = |way_hit;
   wire wbc_way_t hit_way = onehot_way(way_hit);
   wire idle = (state_q == WBC_IDLE) && !op_rst;

   // core side decode
   wire wbuf_ready;
   wire wbuf_valid;
   wire [WB_DW-1:0] wbuf_head;
   wire rd_hit_go = idle && core_req && !core_we && hit; // RL6
   wire rd_miss = idle && core_req && !core_we && !hit; // RL3
   wire wr_post_need = !hit || !wb_mode_in; // RL8 RL9
   wire wr_go = idle && core_req && core_we &&
                (!wr_post_need || wbuf_ready); // RL6
   wire wr_hit_go = wr_go && hit;
   wire wbuf_push = wr_go && wr_post_need; // RL10
   assign core_gnt = rd_hit_go || wr_go;

   // bus engine: one input-clock edge every third core clock
   wire tick = phase_q == 2'(`WBC_CLK_RATIO - 1); // RL11
   wire bus_done = tick && bus_busy_q && bus_ack;
   wire fsm_done = bus_done && bus_fsm_q;

   wire [10:0] m_ix = word_ix(vict_q, m_idx_q, cnt_q);
   wire cur_dirty = dirty_q[m_ix];
   wire fsm_cmd = (state_q == WBC_FILL) ||
                  ((state_q == WBC_WBACK) && cur_dirty); // RL5
   wire [`WBC_TAG_W-1:0] vict_tag = tag_mem[line_ix(vict_q, m_idx_q)];
   wire [31:0] fsm_addr = {(state_q == WBC_WBACK) ? vict_tag : m_tag_q,
                           m_idx_q, cnt_q, 2'h0};
   wire fsm_load = tick && !bus_busy_q && fsm_cmd && !op_rst;
   wire wbuf_pop = tick && !bus_busy_q && !fsm_cmd && wbuf_valid &&
                   !op_rst; // RL10

   wire wb_advance = (state_q == WBC_WBACK) && (!cur_dirty || fsm_done);
   wire fill_start = wb_advance && (cnt_q == 2'h3);
   wire fill_last = (state_q == WBC_FILL) && fsm_done && (cnt_q == 2'h3);
   wire drain_done = (state_q == WBC_DRAIN) && !wbuf_valid && !bus_busy_q;

   wire wbc_way_t lru_victim;
   wire lru_touch = rd_hit_go || wr_hit_go || fill_last; // RL13
   wire [`WBC_IDX_W-1:0] lru_set = fill_last ? m_idx_q : idx;
   wire wbc_way_t lru_way = fill_last ? vict_q : hit_way;

   wbc_lru u_lru (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .touch(lru_touch),
      .touch_set(lru_set),
      .touch_way(lru_way),
      .query_set(idx),
      .victim(lru_victim)
   );

   wbc_wbuf #(.DW(WB_DW), .DEPTH(`WBC_WBUF_DEPTH)) u_wbuf (
      .sys_clk(sys_clk),
      .sys_rst(op_rst),
      .push_valid(wbuf_push),
      .push_ready(wbuf_ready),
      .push_data({core_be, core_addr, core_wdata}),
      .pop_valid(wbuf_valid),
      .pop_ready(wbuf_pop),
      .pop_data(wbuf_head)
   );

   // miss sequencer
   always_ff @(posedge sys_clk) begin
      if (op_rst) begin
         state_q <= WBC_IDLE;
         cnt_q <= 2'h0;
         vict_q <= 2'h0;
         m_tag_q <= '0;
         m_idx_q <= '0;
      end else begin
         unique case (state_q)
            WBC_IDLE: begin
               if (rd_miss) begin
                  state_q <= WBC_DRAIN;
                  m_tag_q <= tag;
                  m_idx_q <= idx;
                  vict_q <= pick_victim(way_valid, lru_victim); // RL2
                  cnt_q <= 2'h0;
               end
            end
            // posted writes must reach memory before the line is read
            WBC_DRAIN: begin
               if (drain_done) state_q <= WBC_WBACK;
            end
            WBC_WBACK: begin
               if (wb_advance) cnt_q <= cnt_q + 2'h1; // RL5
               if (fill_start) state_q <= WBC_FILL;
            end
            WBC_FILL: begin
               if (fsm_done) cnt_q <= cnt_q + 2'h1;
               if (fill_last) state_q <= WBC_IDLE;
            end
         endcase
      end
   end

   // arrays without reset: contents are guarded by valid_q
   always_ff @(posedge sys_clk) begin
      if (wr_hit_go) begin
         data_mem[word_ix(hit_way, idx, word)] <=
            merge(data_mem[word_ix(hit_way, idx, word)], core_wdata,
                  core_be); // RL9
      end else if (fsm_done && (state_q == WBC_FILL)) begin
         data_mem[m_ix] <= bus_rdata;
      end
      if (fill_start) begin
         tag_mem[line_ix(vict_q, m_idx_q)] <= m_tag_q;
      end
   end

   // only a full reset clears all the flags
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         valid_q <= '0;
      end else if (fill_start) begin
         valid_q[line_ix(vict_q, m_idx_q)] <= 1'b0;
      end else if (fill_last) begin
         valid_q[line_ix(vict_q, m_idx_q)] <= 1'b1; // RL4
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dirty_q <= '0;
      end else if (wr_hit_go && wb_mode_in) begin
         dirty_q[word_ix(hit_way, idx, word)] <= 1'b1; // RL4 RL7
      end else if (fsm_done && (state_q == WBC_WBACK)) begin
         dirty_q[m_ix] <= 1'b0;
      end
   end

   // core read data
   always_ff @(posedge sys_clk) begin
      if (op_rst) begin
         core_rvalid_q <= 1'b0;
         core_rdata_q <= 32'h0;
      end else begin
         core_rvalid_q <= rd_hit_go; // RL6
         if (rd_hit_go) core_rdata_q <= data_mem[word_ix(hit_way, idx, word)];
      end
   end

   // bus clock divider keeps running through warm restart
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         phase_q <= 2'h0;
         bus_clk_q <= 1'b0;
      end else begin
         phase_q <= tick ? 2'h0 : phase_q + 2'h1; // RL11
         bus_clk_q <= tick;
      end
   end

   // one bus cycle at a time; a new one starts a bus clock after the last
   always_ff @(posedge sys_clk) begin
      if (op_rst) begin
         bus_busy_q <= 1'b0;
         bus_fsm_q <= 1'b0;
         bus_we_q <= 1'b0;
         bus_addr_q <= 32'h0;
         bus_wdata_q <= 32'h0;
         bus_be_q <= 4'h0;
      end else if (bus_done) begin
         bus_busy_q <= 1'b0;
         bus_fsm_q <= 1'b0;
      end else if (fsm_load) begin
         bus_busy_q <= 1'b1;
         bus_fsm_q <= 1'b1;
         bus_we_q <= state_q == WBC_WBACK;
         bus_addr_q <= fsm_addr;
         bus_wdata_q <= data_mem[m_ix];
         bus_be_q <= `WBC_BE_ALL;
      end else if (wbuf_pop) begin
         bus_busy_q <= 1'b1;
         bus_fsm_q <= 1'b0;
         bus_we_q <= 1'b1; // RL8
         bus_be_q <= wbuf_head[67:64];
         bus_addr_q <= wbuf_head[63:32];
         bus_wdata_q <= wbuf_head[31:0];
      end
   end

   assign core_rvalid = core_rvalid_q;
   assign core_rdata = core_rdata_q;
   assign bus_clk_out = bus_clk_q;
   assign bus_req = bus_busy_q;
   assign bus_we = bus_we_q;
   assign bus_addr = bus_addr_q;
   assign bus_wdata = bus_wdata_q;
   assign bus_be = bus_be_q;
endmodule : wbc_cache
`default_nettype wire

// >>> design/wbc_cache_fix_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> verification/wbc_cache_props.sv
// wbc_cache_props: port-level checker for the unified cache top.
// assumes it is bound to wbc_cache and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module wbc_cache_props (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic warm_restart_in,
   input wire logic core_req,
   input wire logic core_we,
   input wire logic core_gnt,
   input wire logic core_rvalid,
   input wire logic [31:0] core_rdata,
   input wire logic bus_clk_out,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [3:0] bus_be,
   input wire logic bus_ack
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || warm_restart_in);
   chk_read_answer: assert property (
      core_req && core_gnt && !core_we |=> core_rvalid)
      else $error("granted read not answered in the next cycle");
   chk_rvalid_cause: assert property (
      core_rvalid |-> $past(core_req && core_gnt && !core_we))
      else $error("read data valid without a granted read");
   chk_rdata_hold: assert property (
      $changed(core_rdata) |-> core_rvalid)
      else $error("read data changed without a read answer");
   chk_warm_no_gnt: assert property (disable iff (sys_rst)
      warm_restart_in |-> !core_gnt)
      else $error("request granted during warm restart");
   chk_tick_period: assert property (
      bus_clk_out |=> !bus_clk_out ##1 !bus_clk_out ##1 bus_clk_out)
      else $error("bus clock marker not one cycle in three");
   chk_start_tick: assert property (
      $rose(bus_req) |-> bus_clk_out)
      else $error("bus cycle started off the bus clock edge");
   chk_bus_stable: assert property (
      bus_req && $past(bus_req) |-> $stable(bus_addr) && $stable(bus_we)
         && $stable(bus_wdata) && $stable(bus_be))
      else $error("bus cycle qualifiers changed while open");
   chk_bus_close: assert property (
      bus_req && bus_ack && $past(bus_clk_out, 2) |=> !bus_req)
      else $error("acknowledged bus cycle not closed at the tick");
   chk_bus_hold: assert property (
      bus_req && !$past(bus_clk_out, 2) |=> bus_req)
      else $error("bus cycle closed off the tick");
endmodule : wbc_cache_props
bind wbc_cache wbc_cache_props u_props (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .warm_restart_in(warm_restart_in),
   .core_req(core_req), .core_we(core_we), .core_gnt(core_gnt),
   .core_rvalid(core_rvalid), .core_rdata(core_rdata),
   .bus_clk_out(bus_clk_out), .bus_req(bus_req), .bus_we(bus_we),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
   .bus_ack(bus_ack));
`default_nettype wire

// >>> verification/wbc_mem_model.sv
// wbc_mem_model: bus unit and memory behind the cache, one word per cycle.
// assumes bus_ack is only honoured at ticks; slow delays the answer.
`timescale 1ns/1ps
`default_nettype none
module wbc_mem_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] slow,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic [3:0] bus_be,
   output logic bus_ack,
   output logic [31:0] bus_rdata,
   output int wr_count,
   output logic [31:0] last_waddr,
   output logic [31:0] last_wdata
);
   logic [31:0] mem [logic [29:0]];
   logic [3:0] age;
   logic req_q, we_q;
   logic [31:0] w;
   // unwritten words read back as a pattern made from their address
   function automatic logic [31:0] rd(input logic [31:0] a);
      return mem.exists(a[31:2]) ? mem[a[31:2]] : {a[15:0], ~a[15:0]};
   endfunction : rd
   initial begin
      bus_ack = 1'b0;
      bus_rdata = 32'h0;
   end
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_ack <= 1'b0;
         age <= 4'h0;
         req_q <= 1'b0;
         wr_count <= 0;
      end else begin
         req_q <= bus_req;
         we_q <= bus_we;
         age <= !bus_req ? 4'h0 : (age == 4'hf ? age : age + 4'h1);
         bus_ack <= bus_req && age >= slow;
         // released data line toggles so a stale value never passes
         bus_rdata <= bus_req && age >= slow ? rd(bus_addr) : ~bus_rdata;
         if (bus_req && bus_we && bus_ack) begin
            w = rd(bus_addr);
            for (int i = 0; i < 4; i++)
               if (bus_be[i]) w[8*i+:8] = bus_wdata[8*i+:8];
            mem[bus_addr[31:2]] = w;
            last_waddr <= bus_addr;
            last_wdata <= w;
         end
         if (req_q && !bus_req && we_q) wr_count <= wr_count + 1;
      end
   end
endmodule : wbc_mem_model
`default_nettype wire

// >>> verification/writeback_unified_cache_bench.sv
// writeback_unified_cache_bench: directed scenarios for the cache top.
// assumes the bus model answers words and counts completed bus writes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   failures++; $display("CHECK FAILED t=%0t got %h exp %h", $time, \
   a, b); end end
module writeback_unified_cache_bench;
   logic sys_clk = 0, sys_rst = 1, warm = 0, wb = 1, req = 0, we = 0;
   logic [31:0] addr = 0, wd = 0, baddr, bwd, brd, rdata, lwa, lwd;
   logic [3:0] be = 0, slow = 0, bbe;
   logic gnt, rv, bclk, breq, bwe, back;
   int failures = 0, samples_checked = 0, wr_count;
   always #50 sys_clk = ~sys_clk;
   wbc_cache dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .warm_restart_in(warm), .wb_mode_in(wb), .core_req(req),
      .core_we(we), .core_addr(addr), .core_wdata(wd), .core_be(be),
      .core_gnt(gnt), .core_rvalid(rv), .core_rdata(rdata),
      .bus_clk_out(bclk), .bus_req(breq), .bus_we(bwe),
      .bus_addr(baddr), .bus_wdata(bwd), .bus_be(bbe), .bus_ack(back),
      .bus_rdata(brd));
   wbc_mem_model mem (.sys_clk(sys_clk), .sys_rst(sys_rst), .slow(slow),
      .bus_req(breq), .bus_we(bwe), .bus_addr(baddr), .bus_wdata(bwd),
      .bus_be(bbe), .bus_ack(back), .bus_rdata(brd), .wr_count(wr_count),
      .last_waddr(lwa), .last_wdata(lwd));
   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[15:0], ~a[15:0]};
   endfunction : pat
   task automatic finish_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test
   // n counts cycles the request waited for its grant; zero on a read means a hit
   task automatic acc(input logic w, input logic [31:0] a, d,
      input logic [3:0] b, output logic [31:0] r, output int n);
      @(posedge sys_clk);
      req <= 1;
      we <= w;
      addr <= a;
      wd <= d;
      be <= b;
      n = 0;
      @(negedge sys_clk);
      while (gnt !== 1'b1) begin
         if (n == 300) begin
            failures++;
            finish_test();
         end
         @(negedge sys_clk);
         n++;
      end
      @(posedge sys_clk);
      req <= 0;
      @(negedge sys_clk);
      r = rdata;
      if (!w) `CHK(rv, 1'b1)
   endtask : acc
   task automatic rdc(input logic [31:0] a, e, input logic hit);
      logic [31:0] r;
      int n;
      acc(1'b0, a, 32'h0, 4'h0, r, n);
      `CHK(r, e)
      `CHK(n == 0, hit)
   endtask : rdc
   task automatic wr(input logic [31:0] a, d, input logic [3:0] b);
      logic [31:0] r;
      int n;
      acc(1'b1, a, d, b, r, n);
   endtask : wr
   task automatic wait_wr(input int c);
      // sampled mid-cycle so the model's count has settled
      for (int i = 0; i < 300 && wr_count != c; i++) @(negedge sys_clk);
      `CHK(wr_count, c)
   endtask : wait_wr
   task automatic t_miss_hit();
      rdc(32'h100, pat(32'h100), 1'b0);
      rdc(32'h100, pat(32'h100), 1'b1);
   endtask : t_miss_hit
   task automatic t_wb_write();
      int c;
      c = wr_count;
      wr(32'h100, 32'h11223344, 4'h3);
      repeat (30) @(posedge sys_clk);
      `CHK(wr_count, c)
      rdc(32'h100, 32'h01003344, 1'b1);
   endtask : t_wb_write
   task automatic t_wt_write();
      int c;
      @(posedge sys_clk);
      wb <= 0;
      c = wr_count;
      wr(32'h104, 32'hcafef00d, 4'hf);
      wait_wr(c + 1);
      `CHK(lwd, 32'hcafef00d)
      rdc(32'h104, 32'hcafef00d, 1'b1);
      @(posedge sys_clk);
      wb <= 1;
   endtask : t_wt_write
   task automatic t_write_miss();
      int c;
      c = wr_count;
      wr(32'h3000, 32'h5555aaaa, 4'hf);
      wait_wr(c + 1);
      rdc(32'h3000, 32'h5555aaaa, 1'b0);
   endtask : t_write_miss
   // five lines of one set; the dirty one is aged out by later hits
   task automatic t_evict();
      logic [31:0] a [5];
      int c;
      for (int k = 0; k < 5; k++) a[k] = 32'h4050 + k * 32'h800;
      @(posedge sys_clk);
      slow <= 4'h4;
      for (int k = 0; k < 4; k++) rdc(a[k], pat(a[k]), 1'b0);
      wr(a[0] + 32'h4, 32'h0badf00d, 4'hf);
      for (int k = 1; k < 4; k++) rdc(a[k], pat(a[k]), 1'b1);
      c = wr_count;
      rdc(a[4], pat(a[4]), 1'b0);
      `CHK(wr_count, c + 1)
      `CHK(lwa, a[0] + 32'h4)
      rdc(a[1], pat(a[1]), 1'b1);
      rdc(a[0] + 32'h4, 32'h0badf00d, 1'b0);
   endtask : t_evict
   task automatic t_warm();
      @(posedge sys_clk);
      warm <= 1;
      repeat (2) @(posedge sys_clk);
      warm <= 0;
      rdc(32'h4850, pat(32'h4850), 1'b1);
      @(posedge sys_clk);
      sys_rst <= 1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 0;
      rdc(32'h4850, pat(32'h4850), 1'b0);
   endtask : t_warm
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 0;
      t_miss_hit();
      t_wb_write();
      t_wt_write();
      t_write_miss();
      t_evict();
      t_warm();
      finish_test();
   end
endmodule : writeback_unified_cache_bench
`default_nettype wire
